// >>> dbs_pkg.sv
// constants, state type and helpers shared by the sizing multiplexer
package dbs_pkg;
  // size codes on the two size outputs, bytes still to move
  localparam logic [1:0] SZ_LONG = 2'h0;
  localparam logic [1:0] SZ_BYTE = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] SZ_THREE = 2'h3;
  // remaining byte counts
  localparam logic [2:0] CNT_ONE = 3'h1;
  localparam logic [2:0] CNT_TWO = 3'h2;
  localparam logic [2:0] CNT_THREE = 3'h3;
  localparam logic [2:0] CNT_FOUR = 3'h4;
  // steps of a partial cycle
  localparam logic [2:0] STEP_BYTE = 3'h1;
  localparam logic [2:0] STEP_WORD = 3'h2;
  // clock rate, for reference
  localparam int CLK_HZ = 20_000_000;
  // fast termination ends a cycle after this many strobe clocks
  localparam int FAST_TERM_CYCLES = 2;
  // read data buffer depth
  localparam int RD_FIFO_DEPTH = 8;
  // operand word width and lane width
  localparam int OPW = 32;
  localparam int LANEW = 16;

  // operand sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_GAP, ST_BUS, ST_DONE} dbs_state_e;

  // size code announced for a remaining count
  function automatic logic [1:0] dbs_size_code(input logic [2:0] rem);
    logic [1:0] code;
    code = SZ_LONG;
    unique case (rem)
      CNT_ONE: code = SZ_BYTE;
      CNT_TWO: code = SZ_WORD;
      CNT_THREE: code = SZ_THREE;
      default: code = SZ_LONG;
    endcase
    return code;
  endfunction
endpackage

// >>> dbs_sizing_mux.sv
// dynamic bus sizing sequencer, byte lane mux and read data fifo
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// read data fifo
module dbs_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  // pointer wrap needs a power of two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("dbs_fifo depth must be a power of two, at least 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];  // storage
  logic [AW-1:0] wrPtr;  // next slot to fill
  logic [AW-1:0] rdPtr;  // oldest slot
  logic [AW:0] count;  // words held
  wire push = inValid && inReady;
  wire pop = outValid && outReady;
  // full at DEPTH words; the count is one bit wider than the pointers
  assign inReady = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData = mem[rdPtr];

  // pointers and fill count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) wrPtr <= wrPtr + AW'(1);
      if (pop) rdPtr <= rdPtr + AW'(1);
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // storage needs no reset
  always_ff @(posedge clk) begin
    if (push) mem[wrPtr] <= inData;
  end
endmodule

////////////////////////////////////////////////////////////////////////////
// How it works
// - port width decided anew each cycle from acks, or from fastTermWide under fast termination
// - both acks negated keeps the cycle waiting
// - byte ack only ends cycle, 8-bit port
// - word ack only ends cycle, 16-bit port
// - both acks end cycle as 16-bit port
// - long takes two wide or four narrow cycles
// - every cycle first assumes a wide port
// - lane mux steered by size code and offset bit
// - size outputs announce bytes still remaining
// - address holds operand portion, offset bit selects byte
// - reads ignore the lane without requested bytes
// - second narrow cycle of long announces three
// - offset bit high means odd, byte-only boundary
// - at most one aligned word per cycle
// - long on wide port moves high word first
// - only single bytes at odd addresses
// - misaligned access raises error, never runs
// - fast termination ends cycles without acks
// - size codes 01 byte 10 word 11 three 00 long
// - narrow partial cycle: count minus one, address plus one
// - wide partial cycle: count minus two, address plus two
// - single byte write driven on both lanes
module dbs_sizing_mux
  import dbs_pkg::*;
#(
  parameter int FIFO_DEPTH = RD_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // operand request
  input wire logic opValid,
  output logic opReady,
  input wire logic opWrite,
  input wire logic [1:0] opSize,
  input wire logic [OPW-1:0] opAddr,
  input wire logic [OPW-1:0] opWdata,
  output logic opDone,
  output logic addrError,
  // read operands, right justified
  output logic rdValid,
  input wire logic rdReady,
  output logic [OPW-1:0] rdData,
  // fast termination controls
  input wire logic fastTermEn,
  input wire logic fastTermWide,
  // external bus
  output logic [OPW-1:0] busAddr,
  output logic xferSizeHi,
  output logic xferSizeLo,
  output logic busStrobe,
  output logic busWrite,
  output logic [LANEW-1:0] dataOut,
  output logic dataOe_n,
  input wire logic [LANEW-1:0] dataIn,
  input wire logic ackWordPort_n,
  input wire logic ackBytePort_n
);
  if (FIFO_DEPTH < 2) begin : g_chk
    $error("dbs_sizing_mux needs a fifo of at least two words");
  end

  ////////////////////////////////////////////////////////////////////////////
  // state
  dbs_state_e state;  // sequencer
  logic [2:0] remaining;  // bytes still to move
  logic [OPW-1:0] curAddr;  // address of next byte
  logic [OPW-1:0] wBuf;  // write operand, msb first
  logic [OPW-1:0] rBuf;  // read operand, msb first
  logic [1:0] opCode;  // latched operand size
  logic isWrite;  // latched direction
  logic ackWordQ;  // registered word ack
  logic ackByteQ;  // registered byte ack
  logic [1:0] fastCnt;  // fast termination clocks
  logic fifoInReady;  // room for one more read result

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire accept = opValid && opReady;
  // odd word or long, or an unusable three-byte request
  wire misaligned = (opAddr[0] && opSize != SZ_BYTE) || opSize == SZ_THREE;
  wire fastEnd = fastCnt == 2'(FAST_TERM_CYCLES - 1);
  wire anyAck = ackWordQ || ackByteQ;
  // completion from registered acks or from the fast timer
  wire complete = state == ST_BUS && (fastTermEn ? fastEnd : anyAck);
  // both acks fall on the wide side
  wire portWide = fastTermEn ? fastTermWide : ackWordQ;
  // two bytes only on a wide port, at an even address, with two or more left
  wire canPair = portWide && remaining != CNT_ONE && !curAddr[0];
  wire [2:0] moved = canPair ? STEP_WORD : STEP_BYTE;
  wire lastCycle = remaining == moved;
  // byte index counted from the long's top, 0 is the most significant
  wire [1:0] byteIdx = 2'(CNT_FOUR - remaining);
  wire [1:0] nextIdx = byteIdx + 2'h1;
  wire [7:0] wHi = wBuf[{~byteIdx, 3'h0} +: 8];
  wire [7:0] wNext = wBuf[{~nextIdx, 3'h0} +: 8];
  // odd or single byte is copied to both lanes
  wire dupByte = curAddr[0] || remaining == CNT_ONE;
  wire [LANEW-1:0] next_dataOut = {wHi, dupByte ? wHi : wNext};
  wire [1:0] sizeNow = dbs_size_code(remaining);
  // a read needs fifo room before it starts
  assign opReady = state == ST_IDLE && (opWrite || fifoInReady);
  assign busStrobe = state == ST_BUS;

  ////////////////////////////////////////////////////////////////////////////
  // acks sampled once per clock, acted on one clock later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ackWordQ <= 1'b0;
      ackByteQ <= 1'b0;
    end else begin
      ackWordQ <= !ackWordPort_n;
      ackByteQ <= !ackBytePort_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operand sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      remaining <= CNT_ONE;
      curAddr <= '0;
      opCode <= SZ_BYTE;
      isWrite <= 1'b0;
      addrError <= 1'b0;
      opDone <= 1'b0;
      fastCnt <= 2'h0;
    end else begin
      addrError <= accept && misaligned;
      opDone <= complete && lastCycle;
      fastCnt <= (state == ST_BUS && !fastEnd) ? fastCnt + 2'h1 : 2'h0;
      unique case (state)
        // misaligned requests never reach the bus
        ST_IDLE: if (accept && !misaligned) begin
          state <= ST_GAP;
          curAddr <= opAddr;
          opCode <= opSize;
          isWrite <= opWrite;
          remaining <= (opSize == SZ_BYTE) ? CNT_ONE :
                       (opSize == SZ_WORD) ? CNT_TWO : CNT_FOUR;
        end
        // strobe low until stale acks clear, so no ack is reused
        ST_GAP: if (!anyAck) begin
          state <= ST_BUS;
        end
        // wait states while no ack, else step count and address
        ST_BUS: if (complete) begin
          remaining <= remaining - moved;
          curAddr <= curAddr + OPW'(moved);
          state <= lastCycle ? ST_DONE : ST_GAP;
        end
        // one clock to hand the result over
        ST_DONE: state <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write operand, right justified: byte index counts from the long's top,
  // so a short operand's byte 0 sits just above its remaining bytes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wBuf <= '0;
    end else if (accept && !misaligned) begin
      wBuf <= (opSize == SZ_BYTE) ? {24'h00_0000, opWdata[7:0]} :
              (opSize == SZ_WORD) ? {16'h0000, opWdata[15:0]} : opWdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read capture; the unused lane is never looked at
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rBuf <= '0;
    end else if (complete && !isWrite) begin
      if (!portWide) begin
        rBuf[{~byteIdx, 3'h0} +: 8] <= dataIn[15:8];
      end else if (curAddr[0]) begin
        rBuf[{~byteIdx, 3'h0} +: 8] <= dataIn[7:0];
      end else begin
        rBuf[{~byteIdx, 3'h0} +: 8] <= dataIn[15:8];
        if (canPair) begin
          rBuf[{~nextIdx, 3'h0} +: 8] <= dataIn[7:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered bus outputs; the gap clock lets them settle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dataOut <= '0;
      dataOe_n <= 1'b1;
      xferSizeHi <= 1'b0;
      xferSizeLo <= 1'b1;
      busAddr <= '0;
      busWrite <= 1'b0;
    end else begin
      dataOut <= next_dataOut;
      dataOe_n <= !(isWrite && (state == ST_GAP || state == ST_BUS));
      xferSizeHi <= sizeNow[1];
      xferSizeLo <= sizeNow[0];
      busAddr <= curAddr;
      busWrite <= isWrite;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read result buffer; full stalls new reads at opReady
  // short reads land in the low bytes; upper bytes may be stale, so mask
  wire [OPW-1:0] rdJust = (opCode == SZ_BYTE) ? {24'h00_0000, rBuf[7:0]} :
                          (opCode == SZ_WORD) ? {16'h0000, rBuf[15:0]} : rBuf;
  dbs_fifo #(.WIDTH(OPW), .DEPTH(FIFO_DEPTH)) u_rdFifo (
    .clk(clk),
    .rst_n(rst_n),
    .inValid(state == ST_DONE && !isWrite),
    .inReady(fifoInReady),
    .inData(rdJust),
    .outValid(rdValid),
    .outReady(rdReady),
    .outData(rdData)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_wait_no_ack: assert property (@(posedge clk) disable iff (!rst_n)
    state == ST_BUS && !fastTermEn && !anyAck |=> state == ST_BUS)
    else $error("cycle ended without an acknowledge");
  chk_narrow_step: assert property (@(posedge clk) disable iff (!rst_n)
    complete && !portWide |=> remaining == $past(remaining) - 3'h1 &&
    curAddr == $past(curAddr) + 32'h0000_0001)
    else $error("narrow port step wrong");
  chk_wide_step: assert property (@(posedge clk) disable iff (!rst_n)
    complete && portWide && remaining >= CNT_TWO && !curAddr[0] |=>
    curAddr == $past(curAddr) + 32'h0000_0002)
    else $error("wide port step wrong");
  chk_both_ack_wide: assert property (@(posedge clk) disable iff (!rst_n)
    complete && !fastTermEn && ackWordQ && ackByteQ && !curAddr[0] &&
    remaining != CNT_ONE |=> remaining == $past(remaining) - CNT_TWO)
    else $error("both acks not treated as wide");
  chk_misalign_err: assert property (@(posedge clk) disable iff (!rst_n)
    accept && misaligned |=> addrError && state == ST_IDLE ##1 !busStrobe)
    else $error("misaligned access not refused");
  chk_size_code: assert property (@(posedge clk) disable iff (!rst_n)
    state == ST_BUS |-> {xferSizeHi, xferSizeLo} == dbs_size_code(remaining))
    else $error("size outputs disagree with remaining count");
  chk_byte_lanes: assert property (@(posedge clk) disable iff (!rst_n)
    state == ST_BUS && isWrite && remaining == CNT_ONE |->
    dataOut[15:8] == dataOut[7:0] && !dataOe_n)
    else $error("single byte not on both lanes");
  chk_aligned_pair: assert property (@(posedge clk) disable iff (!rst_n)
    complete && curAddr[0] |=> remaining == $past(remaining) - STEP_BYTE)
    else $error("more than one byte moved at an odd address");
  chk_fast_term: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(busStrobe) && fastTermEn |=> busStrobe ##1 !busStrobe)
    else $error("fast termination length wrong");
  chk_msw_first: assert property (@(posedge clk) disable iff (!rst_n)
    complete && !isWrite && portWide && remaining == CNT_FOUR |=>
    rBuf[31:16] == $past(dataIn))
    else $error("long read high word not first");
endmodule

// >>> dbs_slave_model.sv
// slave model: 8 or 16 bit port with programmable wait states
`timescale 1ns/1ps

module dbs_slave_model (
  // clock and bus from the master
  input wire logic clk,
  input wire logic busStrobe,
  input wire logic busWrite,
  input wire logic [31:0] busAddr,
  input wire logic xferSizeHi,
  input wire logic xferSizeLo,
  input wire logic [15:0] dataOut,
  // answer side
  output logic [15:0] dataIn,
  output logic ackWordPort_n,
  output logic ackBytePort_n,
  // 0 byte port, 1 word ack, 2 both acks; wait clocks before ack
  input wire logic [1:0] ackMode,
  input wire logic [3:0] waitCnt
);
  logic [7:0] mem [16]; // storage, wraps every 16 bytes
  logic [3:0] cnt; // clocks of the running cycle
  logic [15:0] last; // lanes shown last, inverted when idle
  wire [3:0] a = busAddr[3:0];
  wire wide = ackMode != 2'h0;
  wire one = {xferSizeHi, xferSizeLo} == 2'h1;
  // narrow port sits on 15-8 only, low lane carries junk
  wire [15:0] lanes = !wide ? {mem[a], ~last[7:0]} :
    a[0] ? {~last[15:8], mem[a]} : {mem[a], mem[a + 4'h1]};
  assign dataIn = busStrobe && !busWrite ? lanes : ~last;

  initial begin
    for (int i = 0; i < 16; i++)
      mem[i] = 8'(i * 17);
    cnt = 4'h0;
    last = 16'h0000;
    ackWordPort_n = 1'b1;
    ackBytePort_n = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // acks after the wait count, released once the strobe falls
  always @(posedge clk) begin
    if (!busStrobe) begin
      cnt <= 4'h0;
      ackWordPort_n <= 1'b1; // both negated holds the cycle
      ackBytePort_n <= 1'b1;
    end else begin
      if (cnt != 4'hf)
        cnt <= cnt + 4'h1;
      if (cnt >= waitCnt) begin
        ackWordPort_n <= !wide; // wide slave always answers word
        ackBytePort_n <= ackMode == 2'h1;
      end
      // stores without waiting for acks, so fast cycles land too
      if (busWrite && (!wide || !a[0]))
        mem[a] <= dataOut[15:8];
      if (busWrite && wide && a[0])
        mem[a] <= dataOut[7:0];
      if (busWrite && wide && !a[0] && !one)
        mem[a + 4'h1] <= dataOut[7:0];
      last <= dataIn;
    end
  end
endmodule

// >>> dynamic_bus_sizing_mux_test.sv
// self-checking bench for the sizing multiplexer with a slave model
`timescale 1ns/1ps

module dynamic_bus_sizing_mux_test;
  import dbs_pkg::*;
  logic clk, rst_n, opValid, opReady, opWrite, opDone, addrError;
  logic rdValid, rdReady, fastTermEn, fastTermWide, stall, prevStrobe;
  logic busStrobe, busWrite, dataOe_n, xferSizeHi, xferSizeLo;
  logic ackWordPort_n, ackBytePort_n;
  logic [1:0] opSize, ackMode;
  logic [3:0] waitCnt;
  logic [31:0] opAddr, opWdata, rdData, busAddr;
  logic [15:0] dataOut, dataIn;
  logic [31:0] expQ [$]; // expected read results, oldest first
  logic [5:0] busLog [$]; // size code and low address per bus cycle
  logic [7:0] shadow [16]; // expected slave contents
  int n_fail, checked, nEnd, nErr, cycles;

  dbs_sizing_mux #(.FIFO_DEPTH(8)) DUT (.clk(clk), .rst_n(rst_n),
    .opValid(opValid), .opReady(opReady), .opWrite(opWrite),
    .opSize(opSize), .opAddr(opAddr), .opWdata(opWdata), .opDone(opDone),
    .addrError(addrError), .rdValid(rdValid), .rdReady(rdReady),
    .rdData(rdData), .fastTermEn(fastTermEn), .fastTermWide(fastTermWide),
    .busAddr(busAddr), .xferSizeHi(xferSizeHi), .xferSizeLo(xferSizeLo),
    .busStrobe(busStrobe), .busWrite(busWrite), .dataOut(dataOut),
    .dataOe_n(dataOe_n), .dataIn(dataIn), .ackWordPort_n(ackWordPort_n),
    .ackBytePort_n(ackBytePort_n));
  dbs_slave_model slave (.clk(clk), .busStrobe(busStrobe),
    .busWrite(busWrite), .busAddr(busAddr), .xferSizeHi(xferSizeHi),
    .xferSizeLo(xferSizeLo), .dataOut(dataOut), .dataIn(dataIn),
    .ackWordPort_n(ackWordPort_n), .ackBytePort_n(ackBytePort_n),
    .ackMode(ackMode), .waitCnt(waitCnt));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // watcher: logs bus cycles, takes the oldest note per read result
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      finish_test();
    end
    nEnd += int'(opDone || addrError);
    nErr += int'(addrError);
    if (busStrobe && !prevStrobe)
      busLog.push_back({xferSizeHi, xferSizeLo, busAddr[3:0]});
    prevStrobe <= busStrobe;
    if (busStrobe)
      check("lane enable", 32'(dataOe_n), 32'(!busWrite));
    if (busStrobe && busWrite && !xferSizeHi && xferSizeLo)
      check("byte lanes", 32'(dataOut[15:8]), 32'(dataOut[7:0]));
    if (rdValid && rdReady)
      check("read data", rdData, expQ.pop_front());
  end

  // drain side, stalls at random unless held off
  always @(negedge clk)
    rdReady <= !stall && 1'($urandom);

  // one operand: note expectations, request, wait, compare bus cycles
  task automatic op(logic wr, logic [1:0] sz, logic [31:0] ad);
    int n, e, k, w;
    logic [31:0] a, rd;
    logic bad;
    n = sz == SZ_BYTE ? 1 : sz == SZ_WORD ? 2 : 4;
    bad = sz == SZ_THREE || (sz != SZ_BYTE && ad[0]);
    e = nEnd;
    k = nErr;
    rd = 32'h0;
    {opWrite, opSize, opAddr, opWdata} = {wr, sz, ad, 32'($urandom)};
    for (int i = 0; i < n && !bad; i++) begin
      if (wr)
        shadow[4'(ad + i)] = opWdata[8 * (n - 1 - i) +: 8];
      rd = {rd[23:0], shadow[4'(ad + i)]};
    end
    if (!wr && !bad)
      expQ.push_back(rd);
    busLog.delete();
    for (int i = 0; i < 300 && !opReady; i++)
      @(negedge clk);
    opValid = 1'b1;
    @(negedge clk);
    opValid = 1'b0;
    for (int i = 0; i < 400 && nEnd == e; i++)
      @(negedge clk);
    check("error", 32'(nErr - k), 32'(bad));
    a = ad;
    while (!bad && n > 0) begin
      w = n == 1 ? SZ_BYTE : n == 2 ? SZ_WORD : n == 3 ? SZ_THREE : SZ_LONG;
      check("cycle", 32'(busLog.pop_front()), {w[1:0], a[3:0]});
      w = ackMode != 2'h0 && !a[0] && n > 1 ? 2 : 1;
      n -= w;
      a += 32'(w);
    end
    check("extra cycles", 32'(busLog.size()), 32'h0);
  endtask

  // pick acknowledge style and timing between operands
  task automatic setup(logic f, logic [1:0] m);
    fastTermEn = f;
    ackMode = m;
    fastTermWide = m != 2'h0;
    waitCnt = f ? 4'hf : 4'($urandom % 4);
  endtask

  task automatic pair(logic [1:0] sz);
    logic [31:0] ad;
    ad = 32'($urandom % 16) & (sz == SZ_BYTE ? 32'hf : 32'he);
    op(1'b1, sz, ad);
    op(1'b0, sz, ad);
  endtask

  task automatic drain();
    stall = 1'b0;
    for (int i = 0; i < 400 && expQ.size() > 0; i++)
      @(negedge clk);
    check("drained", 32'(expQ.size()), 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {rst_n, opValid, opWrite, opSize, opAddr, opWdata} = '0;
    {fastTermEn, fastTermWide, stall, prevStrobe, rdReady} = '0;
    {ackMode, waitCnt, n_fail, checked, nEnd, nErr, cycles} = '0;
    for (int i = 0; i < 16; i++)
      shadow[i] = 8'(i * 17);
    void'($urandom(32'h7db3_105f));
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    // every ack code and size, acknowledged then fast terminated
    for (int f = 0; f < 2; f++)
      for (int m = 0; m < 3; m++)
        for (int s = 1; s < 4; s++) begin
          setup(1'(f), 2'(m));
          pair(s == 3 ? SZ_LONG : 2'(s));
        end
    // misaligned and illegal requests never reach the bus
    op(1'b1, SZ_WORD, 32'h3);
    op(1'b0, SZ_LONG, 32'h5);
    op(1'b0, SZ_THREE, 32'h4);
    // random mix
    for (int i = 0; i < 30; i++) begin
      setup(1'($urandom), 2'($urandom % 3));
      pair(($urandom % 3) == 0 ? SZ_LONG : 2'($urandom % 2 + 1));
    end
    drain();
    // fill the read buffer with the drain stalled, then empty it
    stall = 1'b1;
    for (int i = 0; i < 8; i++)
      op(1'b0, SZ_BYTE, 32'(i));
    opWrite = 1'b0;
    repeat (3) @(negedge clk);
    check("ready when full", 32'(opReady), 32'h0);
    drain();
    finish_test();
  end
endmodule
